// file: shared/rdsc_cfg.svh
`ifndef RDSC_CFG_SVH
`define RDSC_CFG_SVH

// strap level codes (five-level pin, already digitised)
`define RDSC_LVL_OPEN      3'h0
`define RDSC_LVL_GND       3'h1
`define RDSC_LVL_VDD       3'h2
`define RDSC_LVL_PD        3'h3
`define RDSC_LVL_PU        3'h4

// equalizer gain, tenths of dB
`define RDSC_EQ_OPEN       8'h2d
`define RDSC_EQ_GND        8'h4b
`define RDSC_EQ_VDD        8'h5a
`define RDSC_EQ_PD         8'h3c
`define RDSC_EQ_PU         8'h96
`define RDSC_EQ_STEP       8'h0f
`define RDSC_EQ_STRAP_CODE 5'h18
`define RDSC_EQ_RST        5'h18

// de-emphasis magnitude, tenths of dB
`define RDSC_DE_0          8'h00
`define RDSC_DE_35         8'h23
`define RDSC_DE_60         8'h3c
`define RDSC_DE_95         8'h5f
`define RDSC_DE_STRAP_BIT  2
`define RDSC_DE_RST        3'h4

// output swing, mV
`define RDSC_OS_OPEN       12'h3e8
`define RDSC_OS_GND        12'h352
`define RDSC_OS_VDD        12'h44c
`define RDSC_OS_PD         12'h190
`define RDSC_OS_PU         12'h258
`define RDSC_OS_STEP       12'h032
`define RDSC_OS_MAX_CODE   5'h18
`define RDSC_OS_RST        5'h00

// threshold, mV
`define RDSC_TH_OPEN       8'h4b
`define RDSC_TH_GND        8'h64
`define RDSC_TH_VDD        8'h7d
`define RDSC_TH_PD         8'h96
`define RDSC_TH_PU         8'haf
`define RDSC_TH_BASE       8'h4b
`define RDSC_TH_STEP       8'h19
`define RDSC_TH_STRAP_BIT  3
`define RDSC_TH_RST        4'h8

`endif

// file: shared/rdsc_pkg.sv
package rdsc_pkg;
   typedef enum logic [1:0] {
      RDSC_ST_WAIT   = 2'b00,
      RDSC_ST_SAMPLE = 2'b01,
      RDSC_ST_RUN    = 2'b11
   } rdsc_state_t;
endpackage

// file: logic/rdsc_top.sv
// Notes on behaviour
// [R1] eq strap decodes to five receive gains
// [R2] de-emphasis strap decodes to four levels, GND and PU both 6.0 dB
// [R3] swing strap decodes to five swings
// [R4] one threshold strap serves both channels
// [R5] below threshold squelch, above redrive
// [R6] straps sampled once after power-on
// [R7] registers keep own defaults, not straps
// [R8] register values override strap settings
// [R9] host must program all registers
// [R10] host writes only after power-on
// [R11] de-emphasis codes 0-3 set, 4-7 strap
// [R12] swing 50 mV times code, 0 strap
// [R13] threshold codes 0-7 set, 8-15 strap
// [R14] eq code 0x18 gives strap control
// [R15] latched straps stable until next reset
`timescale 1ns/1ps
`default_nettype none
`include "rdsc_cfg.svh"
module rdsc_top
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // strap pins, digitised five-level codes
   input  wire logic [2:0]  chan_a_eq_strap,
   input  wire logic [2:0]  chan_b_eq_strap,
   input  wire logic [2:0]  chan_a_deemph_strap,
   input  wire logic [2:0]  chan_b_deemph_strap,
   input  wire logic [2:0]  chan_a_swing_strap,
   input  wire logic [2:0]  chan_b_swing_strap,
   input  wire logic [2:0]  input_threshold_strap,
   // programmed register fields
   input  wire logic        reg_wr,
   input  wire logic [4:0]  reg_a_eq,
   input  wire logic [4:0]  reg_b_eq,
   input  wire logic [2:0]  reg_a_deemph,
   input  wire logic [2:0]  reg_b_deemph,
   input  wire logic [4:0]  reg_a_swing,
   input  wire logic [4:0]  reg_b_swing,
   input  wire logic [3:0]  reg_a_thresh,
   input  wire logic [3:0]  reg_b_thresh,
   // measured input level per channel, mV
   input  wire logic [7:0]  chan_a_level,
   input  wire logic [7:0]  chan_b_level,
   // resulting settings
   output logic             straps_valid,
   output logic [7:0]       chan_a_eq_gain,
   output logic [7:0]       chan_b_eq_gain,
   output logic [7:0]       chan_a_deemph,
   output logic [7:0]       chan_b_deemph,
   output logic [11:0]      chan_a_swing,
   output logic [11:0]      chan_b_swing,
   output logic [7:0]       chan_a_thresh,
   output logic [7:0]       chan_b_thresh,
   output logic             chan_a_squelch,
   output logic             chan_b_squelch
);

   // ---------------------------------------------
   // decode functions
   // ---------------------------------------------
   function automatic logic [7:0] eq_dec(input logic [2:0] l);
      case (l)
         `RDSC_LVL_GND: eq_dec = `RDSC_EQ_GND;
         `RDSC_LVL_VDD: eq_dec = `RDSC_EQ_VDD;
         `RDSC_LVL_PD:  eq_dec = `RDSC_EQ_PD;
         `RDSC_LVL_PU:  eq_dec = `RDSC_EQ_PU;
         default:       eq_dec = `RDSC_EQ_OPEN;
      endcase
   endfunction

   function automatic logic [7:0] de_dec(input logic [2:0] l);
      case (l)
         `RDSC_LVL_GND: de_dec = `RDSC_DE_60;
         `RDSC_LVL_VDD: de_dec = `RDSC_DE_95;
         `RDSC_LVL_PD:  de_dec = `RDSC_DE_0;
         `RDSC_LVL_PU:  de_dec = `RDSC_DE_60;
         default:       de_dec = `RDSC_DE_35;
      endcase
   endfunction

   function automatic logic [11:0] os_dec(input logic [2:0] l);
      case (l)
         `RDSC_LVL_GND: os_dec = `RDSC_OS_GND;
         `RDSC_LVL_VDD: os_dec = `RDSC_OS_VDD;
         `RDSC_LVL_PD:  os_dec = `RDSC_OS_PD;
         `RDSC_LVL_PU:  os_dec = `RDSC_OS_PU;
         default:       os_dec = `RDSC_OS_OPEN;
      endcase
   endfunction

   function automatic logic [7:0] th_dec(input logic [2:0] l);
      case (l)
         `RDSC_LVL_GND: th_dec = `RDSC_TH_GND;
         `RDSC_LVL_VDD: th_dec = `RDSC_TH_VDD;
         `RDSC_LVL_PD:  th_dec = `RDSC_TH_PD;
         `RDSC_LVL_PU:  th_dec = `RDSC_TH_PU;
         default:       th_dec = `RDSC_TH_OPEN;
      endcase
   endfunction

   // register code over strap value, eq gain in 1.5 dB steps
   function automatic logic [7:0] eq_sel(input logic [4:0] c, input logic [7:0] s);
      if (c == `RDSC_EQ_STRAP_CODE)
         eq_sel = s;
      else
         eq_sel = 8'(c * `RDSC_EQ_STEP);
   endfunction

   function automatic logic [7:0] de_sel(input logic [2:0] c, input logic [7:0] s);
      if (c[`RDSC_DE_STRAP_BIT])
         de_sel = s;
      else
         case (c[1:0])
            2'h0:    de_sel = `RDSC_DE_0;
            2'h1:    de_sel = `RDSC_DE_35;
            2'h2:    de_sel = `RDSC_DE_60;
            default: de_sel = `RDSC_DE_95;
         endcase
   endfunction

   // codes above 24 are not defined; treated as strap control
   function automatic logic [11:0] os_sel(input logic [4:0] c, input logic [11:0] s);
      if (c == `RDSC_OS_RST || c > `RDSC_OS_MAX_CODE)
         os_sel = s;
      else
         os_sel = 12'(c * `RDSC_OS_STEP);
   endfunction

   function automatic logic [7:0] th_sel(input logic [3:0] c, input logic [7:0] s);
      if (c[`RDSC_TH_STRAP_BIT])
         th_sel = s;
      else
         th_sel = 8'(`RDSC_TH_BASE + c[2:0] * `RDSC_TH_STEP);
   endfunction

   // ---------------------------------------------
   // strap and level synchronisers
   // ---------------------------------------------
   logic [20:0] strap_s1_q, strap_s2_q;
   logic [15:0] lvl_s1_q, lvl_s2_q;
   // no reset: the chain fills while nrst is held, so sampling sees the pins
   always_ff @(posedge clk)
   begin
      strap_s1_q <= {chan_a_eq_strap, chan_b_eq_strap, chan_a_deemph_strap, chan_b_deemph_strap,
                     chan_a_swing_strap, chan_b_swing_strap, input_threshold_strap};
      strap_s2_q <= strap_s1_q;
      lvl_s1_q   <= {chan_a_level, chan_b_level};
      lvl_s2_q   <= lvl_s1_q;
   end

   // ---------------------------------------------
   // power-on sampling sequence
   // ---------------------------------------------
   rdsc_pkg::rdsc_state_t st_q;
   always_ff @(posedge clk)
   begin
      if (!nrst)
         st_q <= rdsc_pkg::RDSC_ST_WAIT;
      else
         case (st_q)
            rdsc_pkg::RDSC_ST_WAIT:   st_q <= rdsc_pkg::RDSC_ST_SAMPLE;
            rdsc_pkg::RDSC_ST_SAMPLE: st_q <= rdsc_pkg::RDSC_ST_RUN; // R6
            rdsc_pkg::RDSC_ST_RUN:    st_q <= rdsc_pkg::RDSC_ST_RUN; // R15
            default:                  st_q <= rdsc_pkg::RDSC_ST_WAIT;
         endcase
   end

   // latched strap decodes, taken once after the synchroniser has filled
   logic [7:0]  a_eq_s_q, b_eq_s_q, a_de_s_q, b_de_s_q, th_s_q;
   logic [11:0] a_os_s_q, b_os_s_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         a_eq_s_q <= `RDSC_EQ_OPEN;
         b_eq_s_q <= `RDSC_EQ_OPEN;
         a_de_s_q <= `RDSC_DE_35;
         b_de_s_q <= `RDSC_DE_35;
         a_os_s_q <= `RDSC_OS_OPEN;
         b_os_s_q <= `RDSC_OS_OPEN;
         th_s_q   <= `RDSC_TH_OPEN;
      end
      else if (st_q == rdsc_pkg::RDSC_ST_SAMPLE) // R6 R15
      begin
         a_eq_s_q <= eq_dec(strap_s2_q[20:18]); // R1
         b_eq_s_q <= eq_dec(strap_s2_q[17:15]); // R1
         a_de_s_q <= de_dec(strap_s2_q[14:12]); // R2
         b_de_s_q <= de_dec(strap_s2_q[11:9]); // R2
         a_os_s_q <= os_dec(strap_s2_q[8:6]); // R3
         b_os_s_q <= os_dec(strap_s2_q[5:3]); // R3
         th_s_q   <= th_dec(strap_s2_q[2:0]); // R4
      end
   end

   // ---------------------------------------------
   // programmed registers, own reset defaults
   // ---------------------------------------------
   logic [4:0] a_eq_r_q, b_eq_r_q, a_os_r_q, b_os_r_q;
   logic [2:0] a_de_r_q, b_de_r_q;
   logic [3:0] a_th_r_q, b_th_r_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         a_eq_r_q <= `RDSC_EQ_RST; // R7 R14
         b_eq_r_q <= `RDSC_EQ_RST;
         a_de_r_q <= `RDSC_DE_RST; // R7
         b_de_r_q <= `RDSC_DE_RST;
         a_os_r_q <= `RDSC_OS_RST; // R7
         b_os_r_q <= `RDSC_OS_RST;
         a_th_r_q <= `RDSC_TH_RST; // R7
         b_th_r_q <= `RDSC_TH_RST;
      end
      else if (reg_wr)
      begin
         a_eq_r_q <= reg_a_eq;
         b_eq_r_q <= reg_b_eq;
         a_de_r_q <= reg_a_deemph;
         b_de_r_q <= reg_b_deemph;
         a_os_r_q <= reg_a_swing;
         b_os_r_q <= reg_b_swing;
         a_th_r_q <= reg_a_thresh;
         b_th_r_q <= reg_b_thresh;
      end
   end

   // ---------------------------------------------
   // resolved settings and squelch
   // ---------------------------------------------
   logic [7:0] a_th_d, b_th_d;
   assign a_th_d = th_sel(a_th_r_q, th_s_q); // R13
   assign b_th_d = th_sel(b_th_r_q, th_s_q); // R13
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         straps_valid   <= 1'b0;
         chan_a_eq_gain <= `RDSC_EQ_OPEN;
         chan_b_eq_gain <= `RDSC_EQ_OPEN;
         chan_a_deemph  <= `RDSC_DE_35;
         chan_b_deemph  <= `RDSC_DE_35;
         chan_a_swing   <= `RDSC_OS_OPEN;
         chan_b_swing   <= `RDSC_OS_OPEN;
         chan_a_thresh  <= `RDSC_TH_OPEN;
         chan_b_thresh  <= `RDSC_TH_OPEN;
         chan_a_squelch <= 1'b1;
         chan_b_squelch <= 1'b1;
      end
      else
      begin
         straps_valid   <= (st_q == rdsc_pkg::RDSC_ST_RUN);
         chan_a_eq_gain <= eq_sel(a_eq_r_q, a_eq_s_q); // R8 R14
         chan_b_eq_gain <= eq_sel(b_eq_r_q, b_eq_s_q); // R8 R14
         chan_a_deemph  <= de_sel(a_de_r_q, a_de_s_q); // R8 R11
         chan_b_deemph  <= de_sel(b_de_r_q, b_de_s_q); // R8 R11
         chan_a_swing   <= os_sel(a_os_r_q, a_os_s_q); // R8 R12
         chan_b_swing   <= os_sel(b_os_r_q, b_os_s_q); // R8 R12
         chan_a_thresh  <= a_th_d; // R8
         chan_b_thresh  <= b_th_d; // R8
         // squelched until straps are known, then by level
         chan_a_squelch <= (st_q != rdsc_pkg::RDSC_ST_RUN) || (lvl_s2_q[15:8] < a_th_d); // R5
         chan_b_squelch <= (st_q != rdsc_pkg::RDSC_ST_RUN) || (lvl_s2_q[7:0] < b_th_d); // R5
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   squelch_a_a: assert property (@(posedge clk) disable iff (!nrst) st_q == rdsc_pkg::RDSC_ST_RUN |=> // R5
      chan_a_squelch == ($past(lvl_s2_q[15:8]) < $past(a_th_d))) else $error("channel a squelch wrong");
   strap_hold_a: assert property (@(posedge clk) disable iff (!nrst) st_q == rdsc_pkg::RDSC_ST_RUN |=> // R15
      $stable(th_s_q) && $stable(a_eq_s_q) && $stable(b_os_s_q)) else $error("strap latch changed");
   sample_once_a: assert property (@(posedge clk) disable iff (!nrst) $rose(straps_valid) |-> // R6
      $past(st_q, 2) == rdsc_pkg::RDSC_ST_SAMPLE) else $error("valid without sampling");
   eq_strap_a: assert property (@(posedge clk) disable iff (!nrst) // R14 R1
      a_eq_r_q == `RDSC_EQ_STRAP_CODE && $stable(a_eq_r_q) && $stable(a_eq_s_q) |=> chan_a_eq_gain == $past(a_eq_s_q))
      else $error("eq strap path wrong");
   de_code_a: assert property (@(posedge clk) disable iff (!nrst) a_de_r_q == 3'h3 |=> // R11
      chan_a_deemph == `RDSC_DE_95) else $error("deemph code 3 wrong");
   de_strap_a: assert property (@(posedge clk) disable iff (!nrst) b_de_r_q[2] && $stable(b_de_s_q) |=> // R11 R2
      chan_b_deemph == $past(b_de_s_q)) else $error("deemph strap path wrong");
   swing_code_a: assert property (@(posedge clk) disable iff (!nrst) a_os_r_q == 5'h18 |=> // R12
      chan_a_swing == 12'h4b0) else $error("swing code 24 wrong");
   swing_strap_a: assert property (@(posedge clk) disable iff (!nrst) b_os_r_q == 5'h00 && // R12 R3
      $stable(b_os_s_q) |=> chan_b_swing == $past(b_os_s_q)) else $error("swing strap path wrong");
   thresh_code_a: assert property (@(posedge clk) disable iff (!nrst) b_th_r_q == 4'h7 |=> // R13
      chan_b_thresh == 8'hfa) else $error("threshold code 7 wrong");
   reg_default_a: assert property (@(posedge clk) !nrst |=> a_eq_r_q == 5'h18 && // R7
      a_de_r_q == 3'h4 && a_os_r_q == 5'h00 && b_th_r_q == 4'h8) else $error("register default wrong");
   shared_th_a: assert property (@(posedge clk) disable iff (!nrst) a_th_r_q[3] && b_th_r_q[3] |=> // R4
      chan_a_thresh == chan_b_thresh) else $error("shared threshold differs");

endmodule
`default_nettype wire

// file: verif/rdsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rdsc_host_model
(
   // clock and status
   input  wire logic       clk,
   input  wire logic       straps_valid,
   // board straps
   output logic [2:0]      chan_a_eq_strap,
   output logic [2:0]      chan_b_eq_strap,
   output logic [2:0]      chan_a_deemph_strap,
   output logic [2:0]      chan_b_deemph_strap,
   output logic [2:0]      chan_a_swing_strap,
   output logic [2:0]      chan_b_swing_strap,
   output logic [2:0]      input_threshold_strap,
   // register writes
   output logic            reg_wr,
   output logic [4:0]      reg_a_eq,
   output logic [4:0]      reg_b_eq,
   output logic [2:0]      reg_a_deemph,
   output logic [2:0]      reg_b_deemph,
   output logic [4:0]      reg_a_swing,
   output logic [4:0]      reg_b_swing,
   output logic [3:0]      reg_a_thresh,
   output logic [3:0]      reg_b_thresh,
   // input signal levels
   output logic [7:0]      chan_a_level,
   output logic [7:0]      chan_b_level
);
   initial
   begin
      {chan_a_eq_strap, chan_a_deemph_strap, chan_a_swing_strap} = 9'h000;
      {chan_b_eq_strap, chan_b_deemph_strap, chan_b_swing_strap} = 9'h000;
      input_threshold_strap = 3'h0;
      reg_wr = 1'b0;
      {reg_a_eq, reg_b_eq, reg_a_deemph, reg_b_deemph} = 16'hffff;
      {reg_a_swing, reg_b_swing, reg_a_thresh, reg_b_thresh} = 18'h3ffff;
      {chan_a_level, chan_b_level} = 16'h0000;
   end

   task automatic strap(input logic [2:0] la, lb, lt);
      {chan_a_eq_strap, chan_a_deemph_strap, chan_a_swing_strap} = {la, la, la};
      {chan_b_eq_strap, chan_b_deemph_strap, chan_b_swing_strap} = {lb, lb, lb};
      input_threshold_strap = lt;
   endtask

   task automatic level(input logic [7:0] la, lb);
      {chan_a_level, chan_b_level} = {la, lb};
   endtask

   // every field is written on each call made while straps_valid is high, then released to garbage
   task automatic write(input logic [4:0] ea, eb, input logic [2:0] da, db, input logic [4:0] sa, sb,
                        input logic [3:0] ta, tb);
      begin
         if (straps_valid !== 1'b1)
            return;
         @(posedge clk);
         #1;
         reg_wr = 1'b1;
         {reg_a_eq, reg_b_eq, reg_a_deemph, reg_b_deemph} = {ea, eb, da, db};
         {reg_a_swing, reg_b_swing, reg_a_thresh, reg_b_thresh} = {sa, sb, ta, tb};
         @(posedge clk);
         #1;
         reg_wr = 1'b0;
         {reg_a_eq, reg_b_eq, reg_a_deemph, reg_b_deemph} = ~{ea, eb, da, db};
         {reg_a_swing, reg_b_swing, reg_a_thresh, reg_b_thresh} = ~{sa, sb, ta, tb};
      end
   endtask
endmodule
`default_nettype wire

// file: verif/test_redriver_strap_config_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_redriver_strap_config_select;
   logic clk;
   logic nrst;
   logic [2:0] chan_a_eq_strap, chan_b_eq_strap, chan_a_deemph_strap, chan_b_deemph_strap;
   logic [2:0] chan_a_swing_strap, chan_b_swing_strap, input_threshold_strap, reg_a_deemph, reg_b_deemph;
   logic reg_wr, straps_valid, chan_a_squelch, chan_b_squelch;
   logic [4:0] reg_a_eq, reg_b_eq, reg_a_swing, reg_b_swing;
   logic [3:0] reg_a_thresh, reg_b_thresh;
   logic [7:0] chan_a_level, chan_b_level, chan_a_eq_gain, chan_b_eq_gain, chan_a_deemph, chan_b_deemph;
   logic [7:0] chan_a_thresh, chan_b_thresh;
   logic [11:0] chan_a_swing, chan_b_swing;
   int errors;
   int num_checks;
   localparam logic [11:0] eq_t [5] = '{12'h02d, 12'h04b, 12'h05a, 12'h03c, 12'h096};
   localparam logic [11:0] de_t [5] = '{12'h023, 12'h03c, 12'h05f, 12'h000, 12'h03c};
   localparam logic [11:0] sw_t [5] = '{12'h3e8, 12'h352, 12'h44c, 12'h190, 12'h258};
   localparam logic [11:0] th_t [5] = '{12'h04b, 12'h064, 12'h07d, 12'h096, 12'h0af};
   localparam logic [11:0] de_c [4] = '{12'h000, 12'h023, 12'h03c, 12'h05f};
   localparam logic [4:0] sw_c [8] = '{5'h00, 5'h01, 5'h02, 5'h0c, 5'h17, 5'h18, 5'h19, 5'h1f};

   rdsc_top uut (.clk, .nrst, .chan_a_eq_strap, .chan_b_eq_strap, .chan_a_deemph_strap, .chan_b_deemph_strap,
      .chan_a_swing_strap, .chan_b_swing_strap, .input_threshold_strap, .reg_wr, .reg_a_eq, .reg_b_eq,
      .reg_a_deemph, .reg_b_deemph, .reg_a_swing, .reg_b_swing, .reg_a_thresh, .reg_b_thresh,
      .chan_a_level, .chan_b_level, .straps_valid, .chan_a_eq_gain, .chan_b_eq_gain, .chan_a_deemph,
      .chan_b_deemph, .chan_a_swing, .chan_b_swing, .chan_a_thresh, .chan_b_thresh, .chan_a_squelch,
      .chan_b_squelch);

   rdsc_host_model host (.clk, .straps_valid, .chan_a_eq_strap, .chan_b_eq_strap, .chan_a_deemph_strap,
      .chan_b_deemph_strap, .chan_a_swing_strap, .chan_b_swing_strap, .input_threshold_strap, .reg_wr,
      .reg_a_eq, .reg_b_eq, .reg_a_deemph, .reg_b_deemph, .reg_a_swing, .reg_b_swing, .reg_a_thresh,
      .reg_b_thresh, .chan_a_level, .chan_b_level);

   always #5 clk = ~clk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic power_on(input logic [2:0] la, lb, lt);
      int n;
      begin
         @(posedge clk);
         #1;
         nrst = 1'b0;
         host.strap(la, lb, lt);
         repeat (20) @(posedge clk);
         #1;
         chk({11'h000, straps_valid}, 12'h000);
         chk({10'h000, chan_a_squelch, chan_b_squelch}, 12'h003);
         nrst = 1'b1;
         n = 0;
         while (straps_valid !== 1'b1 && n < 10)
         begin
            @(posedge clk);
            #1;
            n++;
         end
         if (n == 10)
         begin
            errors++;
            results();
         end
      end
   endtask

   task automatic chk_straps(input logic [2:0] i, j);
      chk({4'h0, chan_a_eq_gain}, eq_t[i]);
      chk({4'h0, chan_b_eq_gain}, eq_t[j]);
      chk({4'h0, chan_a_deemph}, de_t[i]);
      chk({4'h0, chan_b_deemph}, de_t[j]);
      chk(chan_a_swing, sw_t[i]);
      chk(chan_b_swing, sw_t[j]);
      chk({4'h0, chan_a_thresh}, th_t[i]);
      chk({4'h0, chan_b_thresh}, th_t[i]);
   endtask

   function automatic logic [11:0] exp_eq(input logic [4:0] c, input logic [2:0] l);
      logic [7:0] g;
      g = c * 8'h0f;
      return (c == 5'h18) ? eq_t[l] : {4'h0, g};
   endfunction

   function automatic logic [11:0] exp_sw(input logic [4:0] c, input logic [2:0] l);
      return (c == 5'h00 || c > 5'h18) ? sw_t[l] : c * 12'h032;
   endfunction

   function automatic logic [11:0] exp_th(input logic [3:0] c);
      return c[3] ? th_t[2] : 12'h04b + c * 12'h019;
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [4:0] ea, eb, sa, sb;
      logic [3:0] ta, tb;
      logic [2:0] da, db;
      clk = 1'b0;
      nrst = 1'b0;
      errors = 0;
      num_checks = 0;
      for (int i = 0; i < 5; i++)
      begin
         power_on(3'(i), 3'((i + 2) % 5), 3'(i));
         chk_straps(3'(i), 3'((i + 2) % 5));
      end
      host.strap(3'h0, 3'h2, 3'h3);
      repeat (10) @(posedge clk);
      #1;
      chk_straps(3'h4, 3'h1);
      $display("strap decode test done");
      power_on(3'h1, 3'h3, 3'h2);
      for (int k = 0; k < 8; k++)
      begin
         {ea, eb, da, db} = {5'(k * 3 + 3), 5'(24 - k * 3), 3'(k), 3'(7 - k)};
         {sa, sb, ta, tb} = {sw_c[k], sw_c[7 - k], 4'(k * 2), 4'(15 - k * 2)};
         chk({11'h000, straps_valid}, 12'h001);
         host.write(ea, eb, da, db, sa, sb, ta, tb);
         repeat (3) @(posedge clk);
         #1;
         chk({4'h0, chan_a_eq_gain}, exp_eq(ea, 3'h1));
         chk({4'h0, chan_b_eq_gain}, exp_eq(eb, 3'h3));
         chk({4'h0, chan_a_deemph}, da[2] ? de_t[1] : de_c[da[1:0]]);
         chk({4'h0, chan_b_deemph}, db[2] ? de_t[3] : de_c[db[1:0]]);
         chk(chan_a_swing, exp_sw(sa, 3'h1));
         chk(chan_b_swing, exp_sw(sb, 3'h3));
         chk({4'h0, chan_a_thresh}, exp_th(ta));
         chk({4'h0, chan_b_thresh}, exp_th(tb));
      end
      $display("register override test done");
      for (int d = 0; d < 3; d++)
      begin
         host.level(8'(124 + d), 8'(99 + d));
         repeat (4) @(posedge clk);
         #1;
         chk({11'h000, chan_a_squelch}, {11'h000, d == 0});
         chk({11'h000, chan_b_squelch}, {11'h000, d == 0});
      end
      $display("squelch test done");
      results();
   end
endmodule
`default_nettype wire
